// *** design/adc_status_irq_mask_regs.v ***
/*
  converter status, interrupt mask and mode registers with result holding,
  range-error, calibration, comparator and gross-overrange flags.
  assumes converter strobes are one-cycle pulses synchronous to clk_in and
  a register port whose read data is taken one cycle after the read strobe.
*/
// Decided for this implementation: the strobed register port.
// Contract
// - status register at 0xffff0500, read only, resets to zero.
// - bit 15 sets on calibration end, clears on any mode register write.
// - bits 14, 13, 12 set on temperature, voltage, current range error.
// - out-of-range result clamps to negative or positive full scale.
// - range-error bit clears when that channel stores an in-range result.
// - with comparator enabled, bit 4 sets when current magnitude exceeds threshold.
// - with threshold counter in use, bit 4 sets when count reaches limit.
// - bit 4 clears on reconfiguration or when the comparator is disabled.
// - with overrange detect enabled, bit 3 sets on gross overrange, checked every 125 us.
// - bit 3 clears only when config bit 2 clears or gain changes.
// - ready bits 2, 1, 0 set when enabled channel stores a result.
// - calibration end also sets the ready bits.
// - temperature ready clears on reading temperature or current result.
// - voltage ready clears on reading voltage or current result.
// - current ready clears on reading current result.
// - mask register at 0xffff0504, read/write, resets to 0x00.
// - 8-bit mode register at 0xffff0508, read/write, resets to 0x00.
// - only low eight status bits feed the interrupt; upper bits are flags.
// - result held until ready clears, except while the core is powered down.
`timescale 1ns/1ps
`include "adc_status_map.vh"

module adc_status_irq_mask_regs #(
  parameter OVR_TICK_CYCLES = `OVR_PERIOD_PS / `CLK_PERIOD_PS,
  parameter RESULT_W = 16
) (
  input wire clk_in,
  input wire rst_b_in,
  // register port
  input wire [`ADDR_W-1:0] addr_in,
  input wire [`DATA_W-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [`DATA_W-1:0] rdata_out,
  // converter side
  input wire cal_done_in,
  input wire cur_valid_in,
  input wire [RESULT_W-1:0] cur_data_in,
  input wire cur_over_in,
  input wire cur_under_in,
  input wire volt_valid_in,
  input wire [RESULT_W-1:0] volt_data_in,
  input wire volt_over_in,
  input wire volt_under_in,
  input wire temp_valid_in,
  input wire [RESULT_W-1:0] temp_data_in,
  input wire temp_over_in,
  input wire temp_under_in,
  input wire gross_overrange_in,
  input wire core_powered_down_in,
  // control and interrupt
  output wire [7:0] mode_out,
  output wire [7:0] config_out,
  output wire [7:0] ctrl_out,
  output wire irq_out
);

  // clamp a result on range error
  function [RESULT_W-1:0] clamp_result;
    input [RESULT_W-1:0] data;
    input over;
    input under;
    begin
      if (under) begin
        clamp_result = `NEG_FULL_SCALE;
      end else if (over) begin
        clamp_result = `POS_FULL_SCALE;
      end else begin
        clamp_result = data;
      end
    end
  endfunction

  // magnitude of a two's complement result
  function [RESULT_W-1:0] magnitude;
    input [RESULT_W-1:0] data;
    begin
      if (data[RESULT_W-1]) begin
        magnitude = (~data) + {{(RESULT_W-1){1'b0}}, 1'b1};
      end else begin
        magnitude = data;
      end
    end
  endfunction

  // register address match
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] reg_addr;
    begin
      hit = (a == reg_addr);
    end
  endfunction

  // zero-extend an 8-bit register to the port width
  function [`DATA_W-1:0] ext8;
    input [7:0] v;
    begin
      ext8 = {{(`DATA_W-8){1'b0}}, v};
    end
  endfunction

  // zero-extend a 16-bit register to the port width
  function [`DATA_W-1:0] ext16;
    input [15:0] v;
    begin
      ext16 = {{(`DATA_W-16){1'b0}}, v};
    end
  endfunction

  // zero-extend a held result to the port width
  function [`DATA_W-1:0] ext_res;
    input [RESULT_W-1:0] v;
    begin
      ext_res = {{(`DATA_W-RESULT_W){1'b0}}, v};
    end
  endfunction

  // an unread result is kept unless the core is powered down
  function may_store;
    input valid;
    input en;
    input rdy;
    input powered_down;
    begin
      may_store = valid && en && (!rdy || powered_down);
    end
  endfunction

  reg [15:0] status_q;
  reg [15:0] status_d;
  reg [7:0] mask_q;
  reg [7:0] mode_q;
  reg [7:0] config_q;
  reg [7:0] ctrl_q;
  reg [RESULT_W-1:0] cur_res_q;
  reg [RESULT_W-1:0] volt_res_q;
  reg [RESULT_W-1:0] temp_res_q;
  reg [15:0] threshold_q;
  reg [7:0] count_limit_q;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg [31:0] tick_cnt_q;
  reg irq_q;
  reg [`DATA_W-1:0] rdata_q;
  reg [`DATA_W-1:0] rdata_d;

  wire wr_mode = wr_in && hit(addr_in, `CONVERTER_MODE_ADDR);
  wire wr_mask = wr_in && hit(addr_in, `CONVERTER_IRQ_MASK_ADDR);
  wire wr_config = wr_in && hit(addr_in, `CONVERTER_CONFIG_ADDR);
  wire wr_ctrl = wr_in && hit(addr_in, `CURRENT_CHANNEL_CTRL_ADDR);
  wire wr_thresh = wr_in && hit(addr_in, `CURRENT_THRESHOLD_ADDR);
  wire wr_limit = wr_in && hit(addr_in, `THRESHOLD_COUNT_LIMIT_ADDR);
  wire rd_cur = rd_in && hit(addr_in, `CURRENT_RESULT_ADDR);
  wire rd_volt = rd_in && hit(addr_in, `VOLTAGE_RESULT_ADDR);
  wire rd_temp = rd_in && hit(addr_in, `TEMP_RESULT_ADDR);

  wire cur_en = config_q[`CFG_CUR_EN];
  wire volt_en = config_q[`CFG_VOLT_EN];
  wire temp_en = config_q[`CFG_TEMP_EN];
  wire cmp_en = config_q[`CFG_CMP_EN];
  wire ovr_en = config_q[`CFG_OVR_EN];

  // result register may take a new value
  wire cur_store = may_store(cur_valid_in, cur_en, status_q[`ST_CUR_RDY],
    core_powered_down_in);
  wire volt_store = may_store(volt_valid_in, volt_en, status_q[`ST_VOLT_RDY],
    core_powered_down_in);
  wire temp_store = may_store(temp_valid_in, temp_en, status_q[`ST_TEMP_RDY],
    core_powered_down_in);

  wire cur_bad = cur_over_in || cur_under_in;
  wire volt_bad = volt_over_in || volt_under_in;
  wire temp_bad = temp_over_in || temp_under_in;

  // comparator on each current conversion
  wire cur_exceeds = cur_valid_in && cur_en && cmp_en &&
    (magnitude(clamp_result(cur_data_in, cur_over_in, cur_under_in)) > threshold_q);
  wire cmp_clear = wr_config || wr_ctrl || !cmp_en;
  wire cfg_ovr_off = wr_config && !wdata_in[`CFG_OVR_EN];
  wire gain_change = wr_ctrl &&
    (wdata_in[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB] != ctrl_q[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB]);
  wire ovr_tick = (tick_cnt_q == OVR_TICK_CYCLES - 1);

  // threshold counter
  always @* begin
    count_d = count_q;
    if (cmp_clear) begin
      count_d = `COUNT_RST;
    end else if (cur_valid_in && cur_en) begin
      if (!cur_exceeds) begin
        count_d = `COUNT_RST;
      end else if (count_q != count_limit_q) begin
        count_d = count_q + 8'h01;
      end
    end
  end

  // status flags: sets win over clears, except the comparator flag and a config write that clears bit 2
  always @* begin
    status_d = status_q;
    // calibration flag
    if (wr_mode) begin
      status_d[`ST_CAL_DONE] = 1'b0;
    end
    if (cal_done_in) begin
      status_d[`ST_CAL_DONE] = 1'b1;
    end
    // range errors
    if (cur_store && !cur_bad) begin
      status_d[`ST_CUR_ERR] = 1'b0;
    end
    if (volt_store && !volt_bad) begin
      status_d[`ST_VOLT_ERR] = 1'b0;
    end
    if (temp_store && !temp_bad) begin
      status_d[`ST_TEMP_ERR] = 1'b0;
    end
    if (cur_valid_in && cur_en && cur_bad) begin
      status_d[`ST_CUR_ERR] = 1'b1;
    end
    if (volt_valid_in && volt_en && volt_bad) begin
      status_d[`ST_VOLT_ERR] = 1'b1;
    end
    if (temp_valid_in && temp_en && temp_bad) begin
      status_d[`ST_TEMP_ERR] = 1'b1;
    end
    // comparator
    if (cmp_clear) begin
      status_d[`ST_CMP] = 1'b0;
    end else if (cur_exceeds && count_limit_q == `COUNT_RST) begin
      status_d[`ST_CMP] = 1'b1;
    end else if (cur_exceeds && count_d == count_limit_q) begin
      status_d[`ST_CMP] = 1'b1;
    end
    // gross overrange
    if (cfg_ovr_off || gain_change) begin
      status_d[`ST_OVR] = 1'b0;
    end
    if (ovr_tick && ovr_en && gross_overrange_in && !cfg_ovr_off) begin
      status_d[`ST_OVR] = 1'b1;
    end
    // ready bits
    if (rd_cur || rd_temp) begin
      status_d[`ST_TEMP_RDY] = 1'b0;
    end
    if (rd_cur || rd_volt) begin
      status_d[`ST_VOLT_RDY] = 1'b0;
    end
    if (rd_cur) begin
      status_d[`ST_CUR_RDY] = 1'b0;
    end
    if (temp_store || cal_done_in) begin
      status_d[`ST_TEMP_RDY] = 1'b1;
    end
    if (volt_store || cal_done_in) begin
      status_d[`ST_VOLT_RDY] = 1'b1;
    end
    if (cur_store || cal_done_in) begin
      status_d[`ST_CUR_RDY] = 1'b1;
    end
    // reserved bits read zero
    status_d[11:5] = 7'h00;
  end

  // read mux, data valid the cycle after the strobe
  always @* begin
    rdata_d = {`DATA_W{1'b0}};
    if (rd_in) begin
      case (addr_in)
        `CONVERTER_STATUS_ADDR: rdata_d = ext16(status_q);
        `CONVERTER_IRQ_MASK_ADDR: rdata_d = ext8(mask_q);
        `CONVERTER_MODE_ADDR: rdata_d = ext8(mode_q);
        `CONVERTER_CONFIG_ADDR: rdata_d = ext8(config_q);
        `CURRENT_CHANNEL_CTRL_ADDR: rdata_d = ext8(ctrl_q);
        `CURRENT_RESULT_ADDR: rdata_d = ext_res(cur_res_q);
        `VOLTAGE_RESULT_ADDR: rdata_d = ext_res(volt_res_q);
        `TEMP_RESULT_ADDR: rdata_d = ext_res(temp_res_q);
        `CURRENT_THRESHOLD_ADDR: rdata_d = ext16(threshold_q);
        `THRESHOLD_COUNT_LIMIT_ADDR: rdata_d = ext8(count_limit_q);
        `THRESHOLD_COUNT_VALUE_ADDR: rdata_d = ext8(count_q);
        default: rdata_d = {`DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_q <= `STATUS_RST;
      mask_q <= `IRQ_MASK_RST;
      mode_q <= `MODE_RST;
      config_q <= `CONFIG_RST;
      ctrl_q <= `CTRL_RST;
      cur_res_q <= `RESULT_RST;
      volt_res_q <= `RESULT_RST;
      temp_res_q <= `RESULT_RST;
      threshold_q <= `THRESHOLD_RST;
      count_limit_q <= `COUNT_RST;
      count_q <= `COUNT_RST;
      tick_cnt_q <= 32'h00000000;
      irq_q <= 1'b0;
      rdata_q <= {`DATA_W{1'b0}};
    end else begin
      status_q <= status_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
      // only the low byte of status can interrupt
      irq_q <= |(status_q[7:0] & mask_q);
      // 125 us evaluation tick
      if (ovr_tick) begin
        tick_cnt_q <= 32'h00000000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
      end
      if (wr_mask) begin
        mask_q <= wdata_in[7:0];
      end
      if (wr_mode) begin
        mode_q <= wdata_in[7:0];
      end
      if (wr_config) begin
        config_q <= wdata_in[7:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata_in[7:0];
      end
      if (wr_thresh) begin
        threshold_q <= wdata_in[15:0];
      end
      if (wr_limit) begin
        count_limit_q <= wdata_in[7:0];
      end
      if (cur_store) begin
        cur_res_q <= clamp_result(cur_data_in, cur_over_in, cur_under_in);
      end
      if (volt_store) begin
        volt_res_q <= clamp_result(volt_data_in, volt_over_in, volt_under_in);
      end
      if (temp_store) begin
        temp_res_q <= clamp_result(temp_data_in, temp_over_in, temp_under_in);
      end
    end
  end

  assign rdata_out = rdata_q;
  assign mode_out = mode_q;
  assign config_out = config_q;
  assign ctrl_out = ctrl_q;
  assign irq_out = irq_q;

endmodule

// *** common/adc_status_map.vh ***
/*
  register map, field positions, reset values and timing for the converter
  status, interrupt mask and mode register bank.
  assumes a byte-addressed 32-bit register port with word-aligned registers.
*/
`ifndef ADC_STATUS_MAP_VH
`define ADC_STATUS_MAP_VH

`define ADDR_W 32
`define DATA_W 32

// register byte addresses
`define CONVERTER_STATUS_ADDR 32'hffff0500
`define CONVERTER_IRQ_MASK_ADDR 32'hffff0504
`define CONVERTER_MODE_ADDR 32'hffff0508
`define CONVERTER_CONFIG_ADDR 32'hffff050c
`define CURRENT_CHANNEL_CTRL_ADDR 32'hffff0510
`define CURRENT_RESULT_ADDR 32'hffff0514
`define VOLTAGE_RESULT_ADDR 32'hffff0518
`define TEMP_RESULT_ADDR 32'hffff051c
`define CURRENT_THRESHOLD_ADDR 32'hffff0520
`define THRESHOLD_COUNT_LIMIT_ADDR 32'hffff0524
`define THRESHOLD_COUNT_VALUE_ADDR 32'hffff0528

// reset values
`define STATUS_RST 16'h0000
`define IRQ_MASK_RST 8'h00
`define MODE_RST 8'h00
`define CONFIG_RST 8'h00
`define CTRL_RST 8'h00
`define RESULT_RST 16'h0000
`define THRESHOLD_RST 16'h0000
`define COUNT_RST 8'h00

// status bit positions
`define ST_CAL_DONE 15
`define ST_TEMP_ERR 14
`define ST_VOLT_ERR 13
`define ST_CUR_ERR 12
`define ST_CMP 4
`define ST_OVR 3
`define ST_TEMP_RDY 2
`define ST_VOLT_RDY 1
`define ST_CUR_RDY 0

// config bit positions
`define CFG_CMP_EN 0
`define CFG_OVR_EN 2
`define CFG_CUR_EN 3
`define CFG_VOLT_EN 4
`define CFG_TEMP_EN 5

// gain field in the current channel control register
`define CTRL_GAIN_LSB 0
`define CTRL_GAIN_MSB 3

// full-scale clamp codes
`define NEG_FULL_SCALE 16'h8000
`define POS_FULL_SCALE 16'h7fff

// timing
`define CLK_PERIOD_PS 5000
`define OVR_PERIOD_PS 125000000

`endif

// *** tb/adc_status_irq_mask_regs_chk.sv ***
/* checker for the converter status, mask and mode register bank.
   assumes it is bound onto the bank's top module and the shared map header. */
`timescale 1ns/1ps
`include "adc_status_map.vh"
module adc_status_irq_mask_regs_chk (
  input wire clk_in,
  input wire rst_b_in,
  input wire [31:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire cal_done_in,
  input wire cur_valid_in,
  input wire cur_over_in,
  input wire cur_under_in,
  input wire [7:0] mode_out,
  input wire [7:0] config_out,
  input wire irq_out
);
  wire rd_st = rd_in && addr_in == `CONVERTER_STATUS_ADDR;
  wire wr_md = wr_in && addr_in == `CONVERTER_MODE_ADDR;
  wire wr_mk = wr_in && addr_in == `CONVERTER_IRQ_MASK_ADDR;
  wire rd_mk = rd_in && addr_in == `CONVERTER_IRQ_MASK_ADDR;
  wire rd_cr = rd_in && addr_in == `CURRENT_RESULT_ADDR;
  wire cur_en = cur_valid_in && config_out[3];
  reg [7:0] mask_q;
  // shadow of the mask register for the interrupt relation
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_q <= 8'h00;
    end else if (wr_mk) begin
      mask_q <= wdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_mode; wr_md |=> mode_out == $past(wdata_in[7:0]); endproperty
  a_mode: assert property (p_mode) else $error("mode not written");
  property p_cal; cal_done_in ##1 rd_st |=> rdata_out[15] && rdata_out[2:0] == 3'h7; endproperty
  a_cal: assert property (p_cal) else $error("calibration flags missing");
  property p_calclr; wr_md && !cal_done_in ##1 rd_st && !cal_done_in |=> !rdata_out[15];
  endproperty
  a_calclr: assert property (p_calclr) else $error("calibration flag kept");
  property p_err; cur_en && (cur_over_in || cur_under_in) ##1 rd_st |=> rdata_out[12];
  endproperty
  a_err: assert property (p_err) else $error("range error flag missing");
  property p_rdyclr; rd_cr && !cur_valid_in && !cal_done_in ##1 rd_st && !cur_valid_in
    && !cal_done_in |=> !rdata_out[0]; endproperty
  a_rdyclr: assert property (p_rdyclr) else $error("ready flag kept");
  property p_mask; wr_mk ##1 rd_mk |=> rdata_out == {24'h0, $past(wdata_in[7:0], 2)};
  endproperty
  a_mask: assert property (p_mask) else $error("mask readback wrong");
  property p_irq; mask_q == 8'h0 && $past(mask_q) == 8'h0 |-> !irq_out; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule

bind adc_status_irq_mask_regs adc_status_irq_mask_regs_chk u_adc_status_irq_mask_regs_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cal_done_in(cal_done_in),
  .cur_valid_in(cur_valid_in), .cur_over_in(cur_over_in), .cur_under_in(cur_under_in),
  .mode_out(mode_out), .config_out(config_out), .irq_out(irq_out));

// *** tb/core_bus_model.sv ***
/* processor core side: makes register writes and reads on the plain port.
   assumes each call starts just after a rising clock edge. */
`timescale 1ns/1ps
module core_bus_model (
  input wire clk_in,
  input wire [31:0] rdata_in,
  output reg [31:0] addr_out = 32'h0,
  output reg [31:0] wdata_out = 32'h0,
  output reg wr_out = 1'b0,
  output reg rd_out = 1'b0
);
  task wr(input [31:0] a, input [31:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
    #1;
  endtask
  task rd(input [31:0] a, output [31:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

// *** tb/tb_adc_status_irq_mask_regs.sv ***
/* testbench for the converter status, mask and mode register bank.
   assumes the core bus model and the shared register map header. */
`timescale 1ns/1ps
`include "adc_status_map.vh"
module tb_adc_status_irq_mask_regs;
  localparam [31:0] A_ST = `CONVERTER_STATUS_ADDR;
  localparam [31:0] A_MK = `CONVERTER_IRQ_MASK_ADDR;
  localparam [31:0] A_MD = `CONVERTER_MODE_ADDR;
  localparam [31:0] A_CF = `CONVERTER_CONFIG_ADDR;
  localparam [31:0] A_CR = `CURRENT_RESULT_ADDR;
  localparam [31:0] A_VR = `VOLTAGE_RESULT_ADDR;
  localparam [31:0] A_TR = `TEMP_RESULT_ADDR;
  reg clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg cal = 1'b0;
  reg gov = 1'b0;
  reg pd = 1'b0;
  reg [2:0] vld = 3'h0;
  reg [2:0] ovr = 3'h0;
  reg [2:0] und = 3'h0;
  reg [15:0] dat = 16'h0;
  wire [31:0] addr, wdata, rdata;
  wire wr, rd, irq;
  wire [7:0] mode, cfg, ctrl;
  integer n_fail = 0;
  integer total_checks = 0;
  always #2.5 clk_in = ~clk_in;
  adc_status_irq_mask_regs #(.OVR_TICK_CYCLES(8), .RESULT_W(16)) u_adc_status_irq_mask_regs (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .cal_done_in(cal), .cur_valid_in(vld[0]),
    .cur_data_in(dat), .cur_over_in(ovr[0]), .cur_under_in(und[0]), .volt_valid_in(vld[1]),
    .volt_data_in(dat), .volt_over_in(ovr[1]), .volt_under_in(und[1]),
    .temp_valid_in(vld[2]), .temp_data_in(dat), .temp_over_in(ovr[2]),
    .temp_under_in(und[2]), .gross_overrange_in(gov), .core_powered_down_in(pd),
    .mode_out(mode), .config_out(cfg), .ctrl_out(ctrl), .irq_out(irq));
  core_bus_model u_core_bus_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task w(input [31:0] a, input [31:0] d);
    u_core_bus_model.wr(a, d);
  endtask
  task rc(input [31:0] a, input [31:0] exp);
    reg [31:0] d;
    u_core_bus_model.rd(a, d);
    chk(d, exp);
  endtask
  task rs(input [15:0] exp);
    reg [31:0] d;
    u_core_bus_model.rd(A_ST, d);
    chk(d & 32'h0000f01f, {16'h0, exp});
  endtask
  // one conversion strobe per channel bit: 0 current, 1 voltage, 2 temperature
  task conv(input [2:0] v, input [15:0] d, input [2:0] o, input [2:0] u);
    vld <= v;
    dat <= d;
    ovr <= o;
    und <= u;
    @(posedge clk_in);
    vld <= 3'h0;
    ovr <= 3'h0;
    und <= 3'h0;
    dat <= ~d;
    #1;
  endtask
  task t_reset;
    rs(16'h0000);
    rc(A_MK, 32'h0);
    rc(A_MD, 32'h0);
    rc(32'hffff05fc, 32'h0);
  endtask
  task t_regs;
    w(A_MK, 32'hff);
    rc(A_MK, 32'hff);
    w(A_MD, 32'ha5);
    rc(A_MD, 32'ha5);
    chk({24'h0, mode}, 32'ha5);
    w(A_ST, 32'hffff);
    rs(16'h0000);
  endtask
  task t_ready;
    w(A_MK, 32'h01);
    w(A_CF, 32'h08);
    chk({24'h0, cfg}, 32'h08);
    conv(3'h7, 16'h5678, 3'h0, 3'h6);
    rs(16'h0001);
    rc(A_CR, 32'h5678);
    w(A_CF, 32'h38);
    conv(3'h7, 16'h1234, 3'h0, 3'h0);
    rs(16'h0007);
    chk({31'h0, irq}, 32'h1);
    rc(A_VR, 32'h1234);
    rs(16'h0005);
    rc(A_TR, 32'h1234);
    rs(16'h0001);
    rc(A_CR, 32'h1234);
    rs(16'h0000);
    chk({31'h0, irq}, 32'h0);
  endtask
  task t_range;
    conv(3'h7, 16'h1234, 3'h7, 3'h0);
    rs(16'h7007);
    rc(A_CR, 32'h7fff);
    conv(3'h7, 16'h1234, 3'h0, 3'h7);
    rc(A_TR, 32'h8000);
    rc(A_CR, 32'h8000);
    conv(3'h7, 16'h0100, 3'h0, 3'h0);
    rs(16'h0007);
    conv(3'h1, 16'h0200, 3'h0, 3'h0);
    rc(A_CR, 32'h0100);
  endtask
  task t_cal;
    w(A_MK, 32'he0);
    cal <= 1'b1;
    @(posedge clk_in);
    cal <= 1'b0;
    #1;
    rs(16'h8007);
    chk({31'h0, irq}, 32'h0);
    w(A_MD, 32'h0);
    rs(16'h0007);
    rc(A_CR, 32'h0100);
  endtask
  task t_cmp;
    w(`CURRENT_THRESHOLD_ADDR, 32'h10);
    w(`THRESHOLD_COUNT_LIMIT_ADDR, 32'h0);
    w(A_CF, 32'h39);
    conv(3'h1, 16'hffe0, 3'h0, 3'h0);
    rs(16'h0011);
    w(A_CF, 32'h39);
    rs(16'h0001);
    w(`THRESHOLD_COUNT_LIMIT_ADDR, 32'h2);
    rc(A_CR, 32'hffe0);
    conv(3'h1, 16'h0020, 3'h0, 3'h0);
    rs(16'h0001);
    rc(A_CR, 32'h0020);
    conv(3'h1, 16'h0020, 3'h0, 3'h0);
    rs(16'h0011);
    w(A_CF, 32'h38);
    rs(16'h0001);
    rc(A_CR, 32'h0020);
  endtask
  task t_ovr;
    integer i;
    reg [31:0] d;
    gov <= 1'b1;
    w(A_CF, 32'h3c);
    d = 32'h0;
    for (i = 0; i < 40 && d[3] !== 1'b1; i = i + 1) begin
      u_core_bus_model.rd(A_ST, d);
    end
    chk({31'h0, d[3]}, 32'h1);
    w(A_CF, 32'h3c);
    rs(16'h0008);
    gov <= 1'b0;
    w(`CURRENT_CHANNEL_CTRL_ADDR, 32'h05);
    rs(16'h0000);
    chk({24'h0, ctrl}, 32'h05);
    gov <= 1'b1;
    d = 32'h0;
    for (i = 0; i < 40 && d[3] !== 1'b1; i = i + 1) begin
      u_core_bus_model.rd(A_ST, d);
    end
    chk({31'h0, d[3]}, 32'h1);
    gov <= 1'b0;
    w(`CURRENT_CHANNEL_CTRL_ADDR, 32'h05);
    rs(16'h0008);
    w(A_CF, 32'h38);
    rs(16'h0000);
    chk({24'h0, cfg}, 32'h38);
  endtask
  task summarize;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1;
    t_reset;
    t_regs;
    t_ready;
    t_range;
    t_cal;
    t_cmp;
    t_ovr;
    summarize;
  end
endmodule
